// ==== rtl/smr_pkg.sv ====
package smr_pkg;

  // single-wire command codes and the read data field
  localparam logic [7:0] CMD_READ_MEM = 8'hf0;
  localparam int MEM_BYTES = 128;
  localparam int ADDR_W = 7;
  localparam int PAGE_LSB = 5;
  localparam int PAGES = 4;
  localparam logic [7:0] UNPROG_BYTE = 8'hff;

  // status memory offsets
  localparam logic [2:0] ST_PROTECT = 3'h0;
  localparam logic [2:0] ST_REDIR_FIRST = 3'h1;
  localparam logic [2:0] ST_REDIR_LAST = 3'h4;
  localparam logic [2:0] ST_TEST = 3'h5;
  localparam logic [2:0] ST_PART = 3'h6;
  localparam logic [2:0] ST_CTRL = 3'h7;
  localparam int ST_EPROM_BYTES = 5;

  // status field layout and fixed values
  localparam logic [7:0] REDIR_FIXED_ONES = 8'hfc;
  localparam logic [7:0] TEST_BYTE_VAL = 8'h00;
  localparam logic [7:0] PART_TAG_DEF = 8'h00;
  localparam logic [6:0] CTRL_RESET = 7'h7f;
  localparam int CTRL_WR_MSB = 6;

  // crc16, reflected form of x^16 + x^15 + x^2 + 1
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] CRC_BIT_LAST = 4'hf;

  localparam int BUF_DEPTH = 2;
  localparam int BUF_W = 1;

  typedef enum logic [2:0] {
    FS_CMD = 3'b000,
    FS_ALO = 3'b001,
    FS_AHI = 3'b011,
    FS_DATA = 3'b010,
    FS_CRC = 3'b110,
    FS_ONES = 3'b111,
    FS_IGNORE = 3'b101
  } smr_fsm_t;

  typedef struct packed {
    logic supply;
    logic sw_b;
    logic sw_a;
    logic [1:0] chan;
    logic [1:0] src;
    logic pol;
  } smr_ctrl_t;

  typedef struct packed {
    logic status_sel;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } smr_prog_t;

endpackage

// ==== rtl/smr_status_read.sv ====
`timescale 1ns/1ps
// Contract
// - a programmed (zero) page lock bit refuses programming of its 32-byte page; reads still allowed
// - used-page bitmap in status byte 0 upper nibble is ignored by logic
// - redirect bytes 1..4 are stored and returned, never steer logic
// - upper six bits of every redirect byte stay at one
// - status byte 5 is the factory test byte, reads 00h
// - status byte 6 is a fixed part tag, always returned on read
// - status byte 7 bits 0..4 hold the search condition selection
// - status byte 7 bits 5 and 6 are the channel A and B flip-flops
// - reset sets search condition bits and both channel flip-flops to one
// - channel flip-flop at 0 turns its open-drain output on, 1 turns it off
// - status byte 7 bit 7 reads the live supply indication
// - a transaction opens with command byte then two address bytes
// - programming is one byte per request, only under the programming level; status byte 7 is written without it
// - every bit moves least significant bit first
// - read command F0h, then low address byte, then high address byte
// - one data bit per read slot, auto-incrementing to end of memory
// - after last byte, sixteen crc bits over command, address and data
// - after the crc every read slot returns one until reset pulse
// - reset pulse aborts the read anywhere; no crc for a cut read
// - commands accepted only after a rom selection since the last reset pulse
module smr_status_read #(
  parameter int MEM_BYTES = smr_pkg::MEM_BYTES,
  parameter int BUF_DEPTH = smr_pkg::BUF_DEPTH,
  parameter int BUF_W = smr_pkg::BUF_W,
  // arbitrary neutral value
  parameter logic [7:0] PART_TAG = smr_pkg::PART_TAG_DEF
) (
  input logic i_clk,
  input logic i_rst,
  input logic i_rst_pulse,
  input logic i_rom_done,
  input logic i_wr_valid,
  input logic i_wr_bit,
  output logic o_rd_valid,
  output logic [BUF_W-1:0] o_rd_bit,
  input logic i_rd_ready,
  input logic i_prog_valid,
  input smr_pkg::smr_prog_t i_prog_req,
  output logic o_prog_done,
  output logic o_prog_refused,
  input logic [2:0] i_st_addr,
  output logic [7:0] o_st_data,
  output smr_pkg::smr_ctrl_t o_ctrl,
  input logic i_supply_pin,
  input logic i_prog_volt_pin,
  output logic o_switch_output_a,
  output logic o_switch_output_a_oe,
  output logic o_switch_output_b,
  output logic o_switch_output_b_oe
);

  localparam int AW = smr_pkg::ADDR_W;
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam logic [AW-1:0] ADDR_LAST = AW'(MEM_BYTES - 1);
  localparam logic [CW-1:0] BUF_FULL = CW'(BUF_DEPTH);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? smr_pkg::CRC_POLY : 16'h0000);
  endfunction

  // nonvolatile storage; persists through i_rst like the cells it models
  logic [7:0] dmem [MEM_BYTES];
  logic [7:0] stmem [smr_pkg::ST_EPROM_BYTES];

  initial begin
    for (int i = 0; i < MEM_BYTES; i++) begin
      dmem[i] = smr_pkg::UNPROG_BYTE;
    end
    for (int i = 0; i < smr_pkg::ST_EPROM_BYTES; i++) begin
      stmem[i] = smr_pkg::UNPROG_BYTE;
    end
  end

  // pin synchronisers
  logic sup_s1_q;
  logic sup_s2_q;
  logic vpp_s1_q;
  logic vpp_s2_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sup_s1_q <= 1'b0;
      sup_s2_q <= 1'b0;
      vpp_s1_q <= 1'b0;
      vpp_s2_q <= 1'b0;
    end else begin
      sup_s1_q <= i_supply_pin;
      sup_s2_q <= sup_s1_q;
      vpp_s1_q <= i_prog_volt_pin;
      vpp_s2_q <= vpp_s1_q;
    end
  end

  // read command engine
  smr_pkg::smr_fsm_t state_q;
  smr_pkg::smr_fsm_t state_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [3:0] bcnt_q;
  logic [3:0] bcnt_d;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] addr_d;
  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic prod_vld;
  logic [BUF_W-1:0] prod_bit;
  logic buf_rdy;
  logic [7:0] rx_byte;
  logic rx_done;
  logic [7:0] rd_byte;

  assign rx_byte = {i_wr_bit, sh_q[7:1]};
  assign rx_done = i_wr_valid && (bcnt_q == smr_pkg::BIT_LAST);

  always_comb begin
    state_d = state_q;
    sh_d = sh_q;
    bcnt_d = bcnt_q;
    addr_d = addr_q;
    crc_d = crc_q;
    prod_vld = 1'b0;
    prod_bit = '1;
    rd_byte = dmem[addr_q];
    case (state_q)
      smr_pkg::FS_CMD, smr_pkg::FS_ALO, smr_pkg::FS_AHI: begin
        if (i_wr_valid) begin
          sh_d = rx_byte;
          crc_d = crc_step(crc_q, i_wr_bit);
          bcnt_d = bcnt_q + 4'h1;
        end
        if (rx_done) begin
          bcnt_d = 4'h0;
          if (state_q == smr_pkg::FS_CMD) begin
            // a command without a prior rom selection is not ours
            if (i_rom_done && rx_byte == smr_pkg::CMD_READ_MEM) begin
              state_d = smr_pkg::FS_ALO;
            end else begin
              state_d = smr_pkg::FS_IGNORE;
            end
          end else if (state_q == smr_pkg::FS_ALO) begin
            // bit 7 dropped; the field holds only 128 bytes
            addr_d = rx_byte[AW-1:0];
            state_d = smr_pkg::FS_AHI;
          end else begin
            state_d = smr_pkg::FS_DATA;
          end
        end
      end
      smr_pkg::FS_DATA: begin
        if (buf_rdy) begin
          prod_vld = 1'b1;
          prod_bit = BUF_W'(rd_byte[bcnt_q[2:0]]);
          crc_d = crc_step(crc_q, rd_byte[bcnt_q[2:0]]);
          bcnt_d = bcnt_q + 4'h1;
          if (bcnt_q == smr_pkg::BIT_LAST) begin
            bcnt_d = 4'h0;
            if (addr_q == ADDR_LAST) begin
              state_d = smr_pkg::FS_CRC;
            end else begin
              addr_d = addr_q + 1'b1;
            end
          end
        end
      end
      smr_pkg::FS_CRC: begin
        if (buf_rdy) begin
          prod_vld = 1'b1;
          prod_bit = BUF_W'(~crc_q[bcnt_q]);
          bcnt_d = bcnt_q + 4'h1;
          if (bcnt_q == smr_pkg::CRC_BIT_LAST) begin
            bcnt_d = 4'h0;
            state_d = smr_pkg::FS_ONES;
          end
        end
      end
      smr_pkg::FS_ONES: begin
        prod_vld = buf_rdy;
        prod_bit = '1;
      end
      default: begin
        state_d = smr_pkg::FS_IGNORE;
      end
    endcase
    // a reset pulse wins over everything and drops the crc
    if (i_rst_pulse) begin
      state_d = smr_pkg::FS_CMD;
      bcnt_d = 4'h0;
      sh_d = 8'h00;
      crc_d = smr_pkg::CRC_INIT;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= smr_pkg::FS_CMD;
      sh_q <= 8'h00;
      bcnt_q <= 4'h0;
      addr_q <= '0;
      crc_q <= smr_pkg::CRC_INIT;
    end else begin
      state_q <= state_d;
      sh_q <= sh_d;
      bcnt_q <= bcnt_d;
      addr_q <= addr_d;
      crc_q <= crc_d;
    end
  end

  // read bit buffer; head entry drives o_rd_bit directly
  logic [BUF_W-1:0] ent_q [BUF_DEPTH];
  logic [BUF_W-1:0] ent_d [BUF_DEPTH];
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic vld_q;
  logic pop;
  logic push;
  logic [CW-1:0] wr_idx;

  assign buf_rdy = (cnt_q != BUF_FULL) && !i_rst_pulse;
  assign push = prod_vld;
  assign pop = vld_q && i_rd_ready;
  assign wr_idx = pop ? cnt_q - CNT_ONE : cnt_q;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CNT_ONE;
    end else if (pop && !push) begin
      cnt_d = cnt_q - CNT_ONE;
    end
    // buffered bits belong to the aborted read
    if (i_rst_pulse) begin
      cnt_d = '0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < BUF_DEPTH; gi++) begin : g_ent
      always_comb begin
        ent_d[gi] = ent_q[gi];
        if (pop) begin
          ent_d[gi] = (gi < BUF_DEPTH - 1) ? ent_q[(gi + 1) % BUF_DEPTH] : ent_q[gi];
        end
        if (push && wr_idx == CW'(gi)) begin
          ent_d[gi] = prod_bit;
        end
      end

      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          ent_q[gi] <= '1;
        end else begin
          ent_q[gi] <= ent_d[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      vld_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      vld_q <= (cnt_d != '0);
    end
  end

  assign o_rd_valid = vld_q;
  assign o_rd_bit = ent_q[0];

  // programming port and status control byte
  smr_pkg::smr_ctrl_t ctrl_q;
  smr_pkg::smr_ctrl_t ctrl_d;
  logic done_d;
  logic refused_d;
  logic dm_we;
  logic st_we;
  logic [2:0] st_wa;
  logic [7:0] wr_data;
  logic [2:0] pa;
  logic [1:0] page;
  logic [3:0] locks;

  assign pa = i_prog_req.addr[2:0];
  assign page = i_prog_req.addr[AW-1:smr_pkg::PAGE_LSB];
  // only the low nibble is looked at; the used-page map is software's
  assign locks = stmem[smr_pkg::ST_PROTECT][smr_pkg::PAGES-1:0];

  always_comb begin
    ctrl_d = ctrl_q;
    ctrl_d.supply = sup_s2_q;
    done_d = 1'b0;
    refused_d = 1'b0;
    dm_we = 1'b0;
    st_we = 1'b0;
    st_wa = pa;
    wr_data = 8'h00;
    if (i_prog_valid) begin
      if (i_prog_req.status_sel) begin
        if (pa == smr_pkg::ST_CTRL) begin
          // ram byte, no programming level needed; supply bit not writable
          ctrl_d[smr_pkg::CTRL_WR_MSB:0] =
            i_prog_req.data[smr_pkg::CTRL_WR_MSB:0];
          done_d = 1'b1;
        end else if (pa > smr_pkg::ST_REDIR_LAST || !vpp_s2_q) begin
          refused_d = 1'b1;
        end else begin
          st_we = 1'b1;
          wr_data = stmem[pa] & i_prog_req.data;
          if (pa >= smr_pkg::ST_REDIR_FIRST) begin
            wr_data = wr_data | smr_pkg::REDIR_FIXED_ONES;
          end
          done_d = 1'b1;
        end
      end else if (locks[page] == 1'b0 || !vpp_s2_q) begin
        // a programmed lock bit reads as zero
        refused_d = 1'b1;
      end else begin
        dm_we = 1'b1;
        wr_data = dmem[i_prog_req.addr] & i_prog_req.data;
        done_d = 1'b1;
      end
    end
  end

  always @(posedge i_clk) begin
    if (dm_we) begin
      dmem[i_prog_req.addr] <= wr_data;
    end
    if (st_we) begin
      stmem[st_wa] <= wr_data;
    end
  end

  // status read port
  logic [7:0] st_rd_d;
  logic [7:0] st_rd_q;

  always_comb begin
    if (i_st_addr <= smr_pkg::ST_REDIR_LAST) begin
      st_rd_d = stmem[i_st_addr];
    end else if (i_st_addr == smr_pkg::ST_TEST) begin
      st_rd_d = smr_pkg::TEST_BYTE_VAL;
    end else if (i_st_addr == smr_pkg::ST_PART) begin
      st_rd_d = PART_TAG;
    end else begin
      st_rd_d = ctrl_q;
    end
  end

  logic sw_a_oe_q;
  logic sw_b_oe_q;
  logic pin_lvl_q;
  logic done_q;
  logic refused_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= {1'b0, smr_pkg::CTRL_RESET};
      sw_a_oe_q <= 1'b0;
      sw_b_oe_q <= 1'b0;
      pin_lvl_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
      st_rd_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      // flip-flop at zero means transistor conducting
      sw_a_oe_q <= ~ctrl_d.sw_a;
      sw_b_oe_q <= ~ctrl_d.sw_b;
      pin_lvl_q <= 1'b0;
      done_q <= done_d;
      refused_q <= refused_d;
      st_rd_q <= st_rd_d;
    end
  end

  assign o_ctrl = ctrl_q;
  assign o_st_data = st_rd_q;
  assign o_prog_done = done_q;
  assign o_prog_refused = refused_q;
  assign o_switch_output_a = pin_lvl_q;
  assign o_switch_output_b = pin_lvl_q;
  assign o_switch_output_a_oe = sw_a_oe_q;
  assign o_switch_output_b_oe = sw_b_oe_q;

endmodule

// ==== testbench/smr_host_model.sv ====
`timescale 1ns/1ps
module smr_host_model (
  input logic i_clk,
  input logic i_rd_valid,
  input logic i_rd_bit,
  output logic o_wr_valid,
  output logic o_wr_bit,
  output logic o_rd_ready
);
  int tmo = 0;
  initial begin
    o_wr_valid = 1'b0;
    o_wr_bit = 1'b0;
    o_rd_ready = 1'b0;
  end
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      o_wr_valid <= 1'b1;
      o_wr_bit <= b[i];
      @(posedge i_clk);
      o_wr_valid <= 1'b0;
      o_wr_bit <= ~b[i]; // released line must not look like data
    end
  endtask
  task automatic start_read(input logic [7:0] cmd, input logic [6:0] a);
    send_byte(cmd);
    send_byte({1'b0, a});
    send_byte(8'h00);
  endtask
  // ready stays high between bytes when stall is zero; a nonzero stall or halt drops it
  task automatic get_byte(input int stall, output logic [7:0] b);
    int n;
    for (int i = 0; i < 8; i++) begin
      if (stall > 0) begin
        o_rd_ready <= 1'b0;
        repeat (stall) @(posedge i_clk);
      end
      o_rd_ready <= 1'b1;
      n = 0;
      do begin
        @(posedge i_clk);
        n++;
      end while (!i_rd_valid && n < 64);
      if (!i_rd_valid) tmo++;
      b[i] = i_rd_bit;
    end
  endtask
  task automatic halt();
    @(posedge i_clk);
    o_rd_ready <= 1'b0;
  endtask
endmodule

// ==== testbench/smr_status_read_bench.sv ====
`timescale 1ns/1ps
module smr_status_read_bench;
  localparam logic [7:0] TAG = 8'h3c; // arbitrary value
  logic i_clk = 0, i_rst = 1, i_rst_pulse = 0, i_rom_done = 1, i_prog_valid = 0;
  smr_pkg::smr_prog_t i_prog_req = '0;
  logic [2:0] i_st_addr = 3'h0;
  logic i_supply_pin = 0, i_prog_volt_pin = 1;
  logic wr_valid, wr_bit, rd_valid, rd_ready, done, refused, oa, oa_oe, ob, ob_oe;
  logic [0:0] rd_bit;
  logic [7:0] st_data, b;
  smr_pkg::smr_ctrl_t ctrl;
  logic [7:0] mem [128];
  int n_fail = 0, compares = 0;
  initial forever #12.5 i_clk = ~i_clk;
  smr_status_read #(.PART_TAG(TAG)) u_smr_status_read (
    .i_clk(i_clk), .i_rst(i_rst), .i_rst_pulse(i_rst_pulse), .i_rom_done(i_rom_done),
    .i_wr_valid(wr_valid), .i_wr_bit(wr_bit), .o_rd_valid(rd_valid), .o_rd_bit(rd_bit),
    .i_rd_ready(rd_ready), .i_prog_valid(i_prog_valid), .i_prog_req(i_prog_req),
    .o_prog_done(done), .o_prog_refused(refused), .i_st_addr(i_st_addr), .o_st_data(st_data),
    .o_ctrl(ctrl), .i_supply_pin(i_supply_pin), .i_prog_volt_pin(i_prog_volt_pin),
    .o_switch_output_a(oa), .o_switch_output_a_oe(oa_oe), .o_switch_output_b(ob),
    .o_switch_output_b_oe(ob_oe));
  smr_host_model u_smr_host_model (.i_clk(i_clk), .i_rd_valid(rd_valid), .i_rd_bit(rd_bit[0]),
    .o_wr_valid(wr_valid), .o_wr_bit(wr_bit), .o_rd_ready(rd_ready));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    n_fail += u_smr_host_model.tmo;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'ha001 : 16'h0000);
    return c;
  endfunction
  task automatic st_rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_st_addr <= a;
    repeat (2) @(posedge i_clk);
    check("status byte", exp, st_data);
  endtask
  task automatic prog(input logic s, input logic [6:0] a, input logic [7:0] d, input logic ok);
    @(posedge i_clk);
    i_prog_valid <= 1'b1;
    i_prog_req <= '{s, a, d};
    @(posedge i_clk);
    i_prog_valid <= 1'b0;
    @(posedge i_clk);
    check("prog accepted", ok, done);
    check("prog refused", !ok, refused);
    if (ok && !s) mem[a] = mem[a] & d;
  endtask
  task automatic pulse();
    @(posedge i_clk);
    i_rst_pulse <= 1'b1;
    @(posedge i_clk);
    i_rst_pulse <= 1'b0;
  endtask
  // stream from a to end of memory, then crc, then idle ones
  task automatic read_to_end(input logic [6:0] a, input int stall);
    logic [15:0] c;
    c = crc8(crc8(crc8(16'h0000, 8'hf0), {1'b0, a}), 8'h00);
    pulse();
    u_smr_host_model.start_read(8'hf0, a);
    for (int i = a; i < 128; i++) begin
      u_smr_host_model.get_byte(stall, b);
      check("data", mem[i], b);
      c = crc8(c, mem[i]);
    end
    c = ~c;
    u_smr_host_model.get_byte(stall, b);
    check("crc low", c[7:0], b);
    u_smr_host_model.get_byte(0, b);
    check("crc high", c[15:8], b);
    u_smr_host_model.get_byte(0, b);
    check("after crc", 8'hff, b);
    u_smr_host_model.halt();
  endtask
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'hff;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    check("ctrl", 8'h7f, ctrl);
    check("oe", 2'b00, {oa_oe, ob_oe});
    $display("test reset done");
    for (int i = 1; i < 5; i++) st_rd(3'(i), 8'hff);
    st_rd(3'h5, 8'h00);
    st_rd(3'h6, TAG);
    prog(1'b1, 7'h05, 8'h00, 1'b0);
    prog(1'b1, 7'h06, 8'h00, 1'b0);
    prog(1'b1, 7'h00, 8'h0e, 1'b1);
    prog(1'b0, 7'h05, 8'h00, 1'b0);
    prog(1'b0, 7'h20, 8'h5a, 1'b1);
    prog(1'b0, 7'h7d, 8'h3c, 1'b1);
    prog(1'b0, 7'h7d, 8'hf0, 1'b1);
    prog(1'b1, 7'h02, 8'h00, 1'b1);
    st_rd(3'h2, 8'hfc);
    prog(1'b1, 7'h01, 8'hfd, 1'b1);
    st_rd(3'h1, 8'hfd);
    st_rd(3'h0, 8'h0e);
    i_prog_volt_pin <= 1'b0;
    repeat (4) @(posedge i_clk);
    prog(1'b0, 7'h40, 8'h00, 1'b0);
    i_prog_volt_pin <= 1'b1;
    prog(1'b1, 7'h07, 8'hbe, 1'b1);
    repeat (2) @(posedge i_clk);
    check("ctrl", 8'h3e, ctrl);
    check("switch pins", 4'b0100, {oa_oe, ob_oe, oa, ob});
    i_supply_pin <= 1'b1;
    repeat (6) @(posedge i_clk);
    check("supply", 1'b1, ctrl.supply);
    $display("test status done");
    read_to_end(7'h7c, 0);
    read_to_end(7'h7a, 2);
    $display("test read done");
    pulse();
    u_smr_host_model.start_read(8'hf0, 7'h1f);
    u_smr_host_model.get_byte(0, b);
    check("data", mem[31], b);
    u_smr_host_model.get_byte(1, b);
    check("data", mem[32], b);
    pulse();
    @(posedge i_clk);
    check("valid after pulse", 1'b0, rd_valid);
    u_smr_host_model.halt();
    i_rom_done <= 1'b0;
    pulse();
    u_smr_host_model.start_read(8'hf0, 7'h00);
    repeat (4) @(posedge i_clk);
    check("valid no rom", 1'b0, rd_valid);
    i_rom_done <= 1'b1;
    pulse();
    u_smr_host_model.start_read(8'h55, 7'h00);
    repeat (4) @(posedge i_clk);
    check("valid bad cmd", 1'b0, rd_valid);
    read_to_end(7'h7e, 1);
    $display("test abort done");
    finish_test();
  end
  initial begin
    repeat (50000) @(posedge i_clk);
    n_fail++;
    finish_test();
  end
endmodule

// ==== testbench/smr_status_read_properties.sv ====
`timescale 1ns/1ps
module smr_status_read_properties (
  input logic i_clk,
  input logic i_rst,
  input logic i_rst_pulse,
  input logic i_prog_valid,
  input smr_pkg::smr_prog_t i_prog_req,
  input logic o_prog_done,
  input logic o_prog_refused,
  input logic o_rd_valid,
  input logic [0:0] o_rd_bit,
  input logic i_rd_ready,
  input smr_pkg::smr_ctrl_t o_ctrl,
  input logic i_supply_pin,
  input logic o_switch_output_a,
  input logic o_switch_output_a_oe,
  input logic o_switch_output_b_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_ctrl_wr;
    i_prog_valid && i_prog_req.status_sel && i_prog_req.addr[2:0] == 3'h7;
  endsequence
  sequence s_ctrl_shown;
    o_prog_done ##1 o_ctrl[6:0] == $past(i_prog_req.data[6:0], 2);
  endsequence
  a_prog_one_answer: assert property (i_prog_valid |=> o_prog_done != o_prog_refused)
    else $error("program request without single answer");
  a_no_idle_answer: assert property (!i_prog_valid |=> !o_prog_done && !o_prog_refused)
    else $error("program answer without request");
  a_fixed_bytes_ro: assert property (i_prog_valid && i_prog_req.status_sel &&
    (i_prog_req.addr[2:0] == 3'h5 || i_prog_req.addr[2:0] == 3'h6) |=> o_prog_refused)
    else $error("fixed status byte accepted a write");
  a_ctrl_write: assert property (s_ctrl_wr |=> s_ctrl_shown)
    else $error("control byte write not shown");
  a_ctrl_reset: assert property (@(posedge i_clk) disable iff (1'b0) i_rst ##1 i_rst |->
    o_ctrl[6:0] == 7'h7f)
    else $error("control byte not all ones in reset");
  a_switch_drive: assert property (o_switch_output_a_oe == !o_ctrl.sw_a &&
    o_switch_output_b_oe == !o_ctrl.sw_b && !o_switch_output_a)
    else $error("switch drive does not follow flip-flops");
  a_read_hold: assert property (o_rd_valid && !i_rd_ready && !i_rst_pulse |=>
    o_rd_valid && $stable(o_rd_bit))
    else $error("stalled read bit changed");
  a_pulse_flush: assert property (i_rst_pulse |=> !o_rd_valid)
    else $error("read continues after reset pulse");
  a_supply_follow: assert property ($stable(i_supply_pin)[*5] |->
    o_ctrl.supply == i_supply_pin)
    else $error("supply bit does not follow pin");
endmodule
bind smr_status_read smr_status_read_properties u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_rst_pulse(i_rst_pulse), .i_prog_valid(i_prog_valid),
  .i_prog_req(i_prog_req), .o_prog_done(o_prog_done), .o_prog_refused(o_prog_refused),
  .o_rd_valid(o_rd_valid), .o_rd_bit(o_rd_bit), .i_rd_ready(i_rd_ready), .o_ctrl(o_ctrl),
  .i_supply_pin(i_supply_pin), .o_switch_output_a(o_switch_output_a),
  .o_switch_output_a_oe(o_switch_output_a_oe), .o_switch_output_b_oe(o_switch_output_b_oe)
);
